// File: hw/etc_pkg.sv
/*
  etc_pkg: constants for the etu time-out counter.
  Assumes one 40 MHz clock domain; no register bus, plain ports only.
*/
package etc_pkg;
  // configuration codes
  localparam logic [7:0] CFG_STOP = 8'h00;
  localparam logic [7:0] CFG_AUTO8 = 8'h05;
  localparam logic [7:0] CFG_SW16 = 8'h61;
  localparam logic [7:0] CFG_AUTO8_SW16 = 8'h65;
  localparam logic [7:0] CFG_SW24 = 8'h68;
  localparam logic [7:0] CFG_SB24 = 8'h7C;
  localparam logic [7:0] CFG_AUTO8_STOP12 = 8'h85;
  localparam logic [7:0] CFG_AUTO8_SW16_STOP12 = 8'hE5;
  // reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // etus counted after the start bit in the stop-after-12 codes
  localparam logic [3:0] STOP_ETUS = 4'hC;
endpackage : etc_pkg

// File: hw/etc_timeout_counter.sv
/*
  etc_timeout_counter: etu time-out counter, 24-bit or 16+8-bit.
  Assumes etu_tick is a one-cycle pulse per etu from the bit-rate
  divider on clk, and card_io comes straight from the pin.
*/
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RULE_01: code 00H halts all counting and events
// RULE_02: code 05H runs low counter autoreload only
// RULE_03: code 61H runs 16-bit counter from write
// RULE_04: 16-bit terminal count interrupts, sets upper flag
// RULE_05: code 65H low counter starts at start bit
// RULE_06: low terminal count interrupts, flags, reloads, repeats
// RULE_07: code 65H 16-bit counts from write, interrupts
// RULE_08: code 68H 24-bit counts from write
// RULE_09: code 7CH 24-bit starts at start bit
// RULE_10: 7CH new values load at next start bit
// RULE_11: host never leaves 7CH count all zero
// RULE_12: 85H stops all after 12th etu received
// RULE_13: E5H stops low counter after 12th etu
// RULE_14: host stops counters before updating counts
// RULE_15: host spaces configuration writes apart
// RULE_16: host uses counters only after activation
// RULE_17: other configuration codes are undefined
// RULE_18: count registers hold number of etus
// RULE_19: count registers clear on reset
// RULE_20: one count per etu tick, interrupt until read
module etc_timeout_counter
  import etc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // etu time base and card line
  input wire logic etu_tick,
  input wire logic card_io,
  input wire logic rx_active,
  // host writes
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic low_wr,
  input wire logic mid_wr,
  input wire logic high_wr,
  input wire logic [7:0] count_wdata,
  input wire logic status_rd,
  // status and interrupt
  output logic [7:0] timeout_config_reg,
  output logic lower_counter_expired_flag,
  output logic upper_counter_expired_flag,
  output logic int_n
);

  ////////////////////////////////////////////////////////////////////
  // registers written by the host

  logic [7:0] count_low_byte;
  logic [7:0] count_mid_byte;
  logic [7:0] count_high_byte;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_low_byte <= COUNT_RESET; // [RULE_19]
      count_mid_byte <= COUNT_RESET; // [RULE_19]
      count_high_byte <= COUNT_RESET; // [RULE_19]
    end else begin
      if (low_wr) count_low_byte <= count_wdata;
      if (mid_wr) count_mid_byte <= count_wdata;
      if (high_wr) count_high_byte <= count_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timeout_config_reg <= CFG_RESET;
    end else if (cfg_wr) begin
      timeout_config_reg <= cfg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // card line synchroniser and start-bit detect

  logic io_meta;
  logic io_sync;
  logic io_prev;
  logic start_bit;
  logic rx_meta;
  logic rx_sync;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_meta <= 1'b1;
      io_sync <= 1'b1;
      io_prev <= 1'b1;
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
    end else begin
      io_meta <= card_io;
      io_sync <= io_meta;
      io_prev <= io_sync;
      rx_meta <= rx_active;
      rx_sync <= rx_meta;
    end
  end

  // falling edge of the idle-high line marks a start bit
  assign start_bit = io_prev & ~io_sync;

  ////////////////////////////////////////////////////////////////////
  // mode decode

  logic low_auto;
  logic low_sb;
  logic mid_sw;
  logic full_sw;
  logic full_sb;
  logic stop12;
  logic stop12_all;

  always_comb begin
    low_auto = 1'b0;
    low_sb = 1'b0;
    mid_sw = 1'b0;
    full_sw = 1'b0;
    full_sb = 1'b0;
    stop12 = 1'b0;
    stop12_all = 1'b0;
    unique case (timeout_config_reg)
      CFG_AUTO8: begin
        low_auto = 1'b1; // [RULE_02]
      end
      CFG_SW16: begin
        mid_sw = 1'b1; // [RULE_03]
      end
      CFG_AUTO8_SW16: begin
        low_auto = 1'b1; // [RULE_05]
        low_sb = 1'b1;
        mid_sw = 1'b1; // [RULE_07]
      end
      CFG_SW24: begin
        full_sw = 1'b1; // [RULE_08]
      end
      CFG_SB24: begin
        full_sb = 1'b1; // [RULE_09]
      end
      CFG_AUTO8_STOP12: begin
        low_auto = 1'b1; // [RULE_12]
        stop12 = 1'b1;
        stop12_all = 1'b1;
      end
      CFG_AUTO8_SW16_STOP12: begin
        low_auto = 1'b1; // [RULE_13]
        low_sb = 1'b1;
        mid_sw = 1'b1;
        stop12 = 1'b1;
      end
      // 00H and undefined codes leave everything halted
      default: begin
      end // [RULE_01] [RULE_17]
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // counters

  logic [7:0] low_cnt;
  logic low_run;
  logic low_armed;
  logic [15:0] mid_cnt;
  logic mid_run;
  logic [23:0] full_cnt;
  logic full_run;
  logic [3:0] etu12_cnt;
  logic etu12_armed;
  logic etu12_done;
  logic low_tc;
  logic mid_tc;
  logic full_tc;
  logic stop12_start;

  // 85H counts from a received start bit, E5H from any start bit
  assign stop12_start = start_bit & (rx_sync | ~stop12_all);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      etu12_cnt <= 4'h0;
      etu12_armed <= 1'b0;
      etu12_done <= 1'b0;
    end else if (cfg_wr) begin
      etu12_cnt <= 4'h0;
      etu12_armed <= 1'b0;
      etu12_done <= 1'b0;
    end else if (stop12 && !etu12_done) begin
      if (!etu12_armed && stop12_start) begin
        etu12_armed <= 1'b1;
      end else if (etu12_armed && etu_tick) begin
        etu12_cnt <= etu12_cnt + 4'h1;
        if (etu12_cnt == STOP_ETUS - 4'h1) begin
          etu12_done <= 1'b1; // [RULE_12] [RULE_13]
        end
      end
    end
  end

  assign low_tc = low_run && etu_tick && (low_cnt <= 8'h01);
  assign mid_tc = mid_run && etu_tick && (mid_cnt <= 16'h0001);
  assign full_tc = full_run && etu_tick && (full_cnt <= 24'h000001);

  // low 8-bit autoreload counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 8'h00;
      low_run <= 1'b0;
      low_armed <= 1'b0;
    end else if (cfg_wr) begin
      low_cnt <= count_low_byte;
      low_run <= 1'b0;
      low_armed <= 1'b1;
    end else if (!low_auto || etu12_done) begin
      low_run <= 1'b0; // [RULE_01] [RULE_12] [RULE_13]
    end else if (low_armed && (!low_sb || start_bit)) begin
      low_cnt <= count_low_byte; // [RULE_05]
      low_run <= 1'b1;
      low_armed <= 1'b0;
    end else if (low_tc) begin
      low_cnt <= count_low_byte; // [RULE_06]
    end else if (low_run && etu_tick) begin
      low_cnt <= low_cnt - 8'h01; // [RULE_18] [RULE_20]
    end
  end

  // joined high and mid bytes as a 16-bit one-shot counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mid_cnt <= 16'h0000;
      mid_run <= 1'b0;
    end else if (cfg_wr) begin
      mid_cnt <= {count_high_byte, count_mid_byte}; // [RULE_03] [RULE_07]
      mid_run <= (cfg_wdata == CFG_SW16) || (cfg_wdata == CFG_AUTO8_SW16)
        || (cfg_wdata == CFG_AUTO8_SW16_STOP12);
    end else if (!mid_sw) begin
      mid_run <= 1'b0; // [RULE_01]
    end else if (mid_tc) begin
      mid_cnt <= 16'h0000;
      mid_run <= 1'b0;
    end else if (mid_run && etu_tick) begin
      mid_cnt <= mid_cnt - 16'h0001; // [RULE_20]
    end
  end

  // all three bytes as one 24-bit counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      full_cnt <= 24'h000000;
      full_run <= 1'b0;
    end else if (cfg_wr) begin
      full_cnt <= {count_high_byte, count_mid_byte, count_low_byte}; // [RULE_08]
      full_run <= (cfg_wdata == CFG_SW24);
    end else if (!full_sw && !full_sb) begin
      full_run <= 1'b0; // [RULE_01]
    end else if (full_sb && start_bit) begin
      // a running count restarts with the latest host values
      full_cnt <= {count_high_byte, count_mid_byte, count_low_byte}; // [RULE_09] [RULE_10]
      full_run <= 1'b1;
    end else if (full_tc) begin
      full_cnt <= 24'h000000;
      full_run <= 1'b0;
    end else if (full_run && etu_tick) begin
      full_cnt <= full_cnt - 24'h000001; // [RULE_18] [RULE_20]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status flags and interrupt

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lower_counter_expired_flag <= 1'b0;
      upper_counter_expired_flag <= 1'b0;
    end else begin
      // a new event in the read cycle wins over the clear
      lower_counter_expired_flag <= low_tc
        || (lower_counter_expired_flag && !status_rd); // [RULE_06]
      upper_counter_expired_flag <= mid_tc || full_tc
        || (upper_counter_expired_flag && !status_rd); // [RULE_04]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !(low_tc || mid_tc || full_tc
        || ((lower_counter_expired_flag || upper_counter_expired_flag)
        && !status_rd)); // [RULE_20]
    end
  end

endmodule : etc_timeout_counter
`default_nettype wire

// File: test/etc_card.sv
/* etc_card: card side model, etu ticks and start bits.
   assumes bench pulses send at the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module etc_card (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bench requests
  input wire logic send,
  input wire logic rx,
  // card side
  output logic etu_tick,
  output logic card_io,
  output logic rx_active
);
  logic [2:0] div;
  logic [3:0] low;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div <= 3'h0;
      low <= 4'h0;
    end else begin
      div <= div + 3'h1;
      low <= send ? 4'h8 : (low != 4'h0 ? low - 4'h1 : 4'h0);
    end
  end
  // line idles high by pull-up
  assign etu_tick = (div == 3'h7);
  assign card_io = (low == 4'h0);
  assign rx_active = (low != 4'h0) & rx;
endmodule : etc_card
`default_nettype wire

// File: test/etc_timeout_counter_assertions.sv
/* etc_checker: port assertions for the etu time-out counter.
   assumes one clock and async active-low nrst. */
`timescale 1ns/10ps
`default_nettype none
module etc_checker
  import etc_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic nrst,
  input wire logic etu_tick,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic status_rd,
  input wire logic [7:0] timeout_config_reg,
  input wire logic lower_counter_expired_flag,
  input wire logic upper_counter_expired_flag,
  input wire logic int_n
);
  wire [7:0] cr = timeout_config_reg;
  wire lo = lower_counter_expired_flag;
  wire up = upper_counter_expired_flag;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  cfg_load_a: assert property (cfg_wr |=> cr == $past(cfg_wdata))
    else $error("config not loaded");
  cfg_hold_a: assert property (!cfg_wr |=> $stable(cr))
    else $error("config changed");
  stop_quiet_a: assert property (cr == 8'h00 && $past(cr) == 8'h00 |=> !$rose(lo) && !$rose(up))
    else $error("event while stopped");
  irq_level_a: assert property (int_n == !(lo || up))
    else $error("interrupt level wrong");
  read_clear_a: assert property (status_rd && !etu_tick |=> !lo && !up)
    else $error("flags not cleared");
  flag_sticky_a: assert property (lo && !status_rd |=> lo)
    else $error("lower flag dropped");
  tick_cause_a: assert property ($rose(lo) || $rose(up) |-> $past(etu_tick, 2) || $past(etu_tick))
    else $error("event without tick");
  upper_mode_a: assert property ($rose(up) |-> $past(cr) inside {8'h61, 8'h65, 8'h68, 8'h7C, 8'hE5})
    else $error("upper flag in wrong mode");
  lower_mode_a: assert property ($rose(lo) |-> $past(cr, 2) inside {8'h05, 8'h65, 8'h85, 8'hE5})
    else $error("lower flag in wrong mode");
endmodule : etc_checker
bind etc_timeout_counter etc_checker i_etc_checker (.clk, .nrst, .etu_tick, .cfg_wr, .cfg_wdata,
  .status_rd, .timeout_config_reg, .lower_counter_expired_flag, .upper_counter_expired_flag, .int_n);
`default_nettype wire

// File: test/tb_top.sv
/* tb_top: self-checking bench for the etu time-out counter.
   assumes etc_card supplies ticks every 8 clocks. */
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import etc_pkg::*;
;
  logic clk = 0, nrst = 0, etu_tick, card_io, rx_active, send, rx;
  logic cfg_wr, low_wr, mid_wr, high_wr, status_rd, lo, up, int_n, plo = 0, pup = 0;
  logic [7:0] cfg_wdata, count_wdata, tcr, n;
  logic [31:0] rs = 32'hE81AD60A;
  logic [13:0] q[$];
  int failures = 0, n_tests = 0, cyc = 0, t[0:2];
  always #12.5 clk = ~clk;
  etc_card i_etc_card (.clk, .nrst, .send, .rx, .etu_tick, .card_io, .rx_active);
  etc_timeout_counter i_etc_timeout_counter (.clk, .nrst, .etu_tick, .card_io, .rx_active,
    .cfg_wr, .cfg_wdata, .low_wr, .mid_wr, .high_wr, .count_wdata, .status_rd,
    .timeout_config_reg(tcr), .lower_counter_expired_flag(lo),
    .upper_counter_expired_flag(up), .int_n);
  task automatic final_report();
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic cmp(input string nm, input logic [13:0] e, input logic [13:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask : cmp
  // one step of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // k: 0 config, 1 low, 2 mid, 3 high
  task automatic wr(input int k, input logic [7:0] d);
    @(negedge clk);
    {high_wr, mid_wr, low_wr, cfg_wr} = 4'h1 << k;
    cfg_wdata = d;
    count_wdata = d;
    @(negedge clk);
    {high_wr, mid_wr, low_wr, cfg_wr} = 4'h0;
  endtask : wr
  // zero a tick count just after a tick
  task automatic align(input int id);
    do @(negedge clk); while (etu_tick !== 1'b1);
    @(negedge clk);
    t[id] = 0;
  endtask : align
  task automatic sb(input int id);
    align(id);
    send = 1;
    @(negedge clk);
    send = 0;
  endtask : sb
  // note expected event, wait for it, then read status
  task automatic ev(input logic [1:0] id, input int c);
    q.push_back({id, c[11:0]});
    for (int i = 0; i < 9000 && (id == 2'h1 ? lo : up) !== 1'b1; i++) @(negedge clk);
    cmp("interrupt", 14'h0, int_n);
    status_rd = 1;
    @(negedge clk);
    status_rd = 0;
    cmp("cleared", 14'h1, {lo, up, int_n});
    @(negedge clk);
  endtask : ev
  // outputs are looked at mid-cycle, settled since the rising edge
  always @(negedge clk) begin
    if (lo === 1'b1 && !plo)
      cmp("lower event", q.size() ? q.pop_front() : 14'h0, {2'h1, t[1][11:0]});
    if (up === 1'b1 && !pup)
      cmp("upper event", q.size() ? q.pop_front() : 14'h0, {2'h2, t[2][11:0]});
    if (lo === 1'b1 && !plo)
      t[1] = 0;
    plo = lo;
    pup = up;
    if (etu_tick) begin
      t[1]++;
      t[2]++;
    end
    if (++cyc > 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    {cfg_wr, low_wr, mid_wr, high_wr, status_rd, send, rx} = 7'h1;
    cfg_wdata = 8'h00;
    count_wdata = 8'h00;
    repeat (5) @(negedge clk);
    nrst = 1;
    cmp("config", CFG_RESET, tcr);
    cmp("flags", 14'h1, {lo, up, int_n});
    align(2);
    wr(0, CFG_SW24);
    ev(2, 1);
    wr(0, CFG_STOP);
    rs = lfsr(rs);
    n = 8'h4 + {6'h0, rs[1:0]};
    wr(1, n);
    wr(2, 8'h1);
    align(2);
    wr(0, CFG_SW24);
    cmp("config", 14'h68, tcr);
    ev(2, 256 + n);
    wr(0, CFG_STOP);
    wr(2, n);
    align(2);
    wr(0, CFG_SW16);
    ev(2, n);
    wr(0, CFG_STOP);
    wr(2, n + 8'h4);
    align(2);
    wr(0, CFG_AUTO8_SW16);
    sb(1);
    ev(1, n);
    ev(2, n + 4);
    ev(1, n);
    wr(0, CFG_STOP);
    repeat (200) @(negedge clk);
    wr(2, 8'h0);
    wr(1, n);
    wr(0, CFG_SB24);
    repeat (40) @(negedge clk);
    sb(2);
    // keep the new byte clear of the start-bit sync latency
    repeat (8) @(negedge clk);
    wr(1, n + 8'h2);
    ev(2, n);
    sb(2);
    ev(2, n + 2);
    wr(0, CFG_STOP);
    wr(2, 8'hC8);
    wr(1, 8'h5);
    align(1);
    wr(0, CFG_AUTO8);
    ev(1, 5);
    ev(1, 5);
    wr(0, CFG_STOP);
    // 85H: a sent start bit must not arm the stop, a received one does
    align(1);
    wr(0, CFG_AUTO8_STOP12);
    rx = 0;
    sb(0);
    repeat (2) align(0);
    rx = 1;
    sb(0);
    repeat (3) ev(1, 5);
    repeat (100) @(negedge clk);
    wr(0, CFG_STOP);
    // E5H: a sent start bit arms the stop of the low counter too
    rx = 0;
    align(1);
    wr(0, CFG_AUTO8_SW16_STOP12);
    sb(1);
    ev(1, 5);
    ev(1, 5);
    repeat (100) @(negedge clk);
    wr(0, CFG_STOP);
    rx = 1;
    cmp("pending", 14'h0, 14'(q.size()));
    final_report();
  end
endmodule : tb_top
`default_nettype wire
